// File: jie_exec.sv
// execute unit for absolute jump and the increment family, with apb control
`timescale 1ns/10ps
`default_nettype none
module jie_exec (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [15:0] INSTR_WORD,
	output logic [20:0] PROG_ADDR,
	output logic [11:0] FILE_ADDR,
	input wire logic [7:0] FILE_RDATA,
	output logic [7:0] FILE_WDATA,
	output logic FILE_WE
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0] ctrl_reg;
	logic [3:0] bank_reg;
	logic [7:0] work_reg;
	logic [11:0] index_reg;
	jie_pkg::jie_flags_t flags_reg;
	logic [20:0] counter_reg;
	logic [15:0] instr_reg;
	logic flush_reg;
	jie_pkg::jie_phase_t phase_reg;
	jie_pkg::jie_op_t op_reg;
	jie_pkg::jie_op_t op_next;
	logic dest_reg;
	logic [7:0] lit_lo_reg;
	logic [7:0] operand_reg;
	logic [7:0] result_reg;
	jie_pkg::jie_flags_t res_flags_reg;
	logic [11:0] file_addr_reg;
	logic [11:0] file_addr_next;
	logic [7:0] file_wdata_reg;
	logic file_we_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_mux;
	logic addr_hit;
	logic apb_done;
	logic apb_wr;
	logic run;
	logic [7:0] inc_result;
	jie_pkg::jie_flags_t inc_flags;
	logic skip;

	assign run = ctrl_reg[jie_pkg::JIE_CTRL_RUN_BIT];

	// ----------------------------------------------------------------
	// apb slave, one wait state
	// ----------------------------------------------------------------
	always_comb begin
		addr_hit = 1'b1;
		rd_mux = 32'h00000000;
		unique case (PADDR)
			jie_pkg::JIE_OFF_CTRL: rd_mux = {30'h00000000, ctrl_reg};
			jie_pkg::JIE_OFF_BANK: rd_mux = {28'h0000000, bank_reg};
			jie_pkg::JIE_OFF_WORK: rd_mux = {24'h000000, work_reg};
			jie_pkg::JIE_OFF_FLAGS: rd_mux = {27'h0000000, flags_reg};
			jie_pkg::JIE_OFF_COUNTER: rd_mux = {11'h000, counter_reg};
			jie_pkg::JIE_OFF_INDEX: rd_mux = {20'h00000, index_reg};
			default: addr_hit = 1'b0;
		endcase
	end

	assign apb_done = PSEL & PENABLE & pready_reg;
	assign apb_wr = apb_done & PWRITE & addr_hit;

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= PSEL & PENABLE & ~pready_reg;
			pslverr_reg <= PSEL & PENABLE & ~pready_reg & ~addr_hit;
			if (PSEL & PENABLE & ~pready_reg) begin
				prdata_reg <= PWRITE ? 32'h00000000 : rd_mux;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= jie_pkg::JIE_CTRL_RST;
			bank_reg <= jie_pkg::JIE_BANK_RST;
			index_reg <= jie_pkg::JIE_INDEX_RST;
		end else if (apb_wr) begin
			if (PADDR == jie_pkg::JIE_OFF_CTRL) begin
				ctrl_reg <= PWDATA[1:0];
			end
			if (PADDR == jie_pkg::JIE_OFF_BANK) begin
				bank_reg <= PWDATA[3:0];
			end
			if (PADDR == jie_pkg::JIE_OFF_INDEX) begin
				index_reg <= PWDATA[11:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// quarter phases
	// ----------------------------------------------------------------
	// halted core parks in Q1 so a restart always begins on a cycle boundary
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			phase_reg <= jie_pkg::PH_Q1;
		end else if (!run) begin
			phase_reg <= jie_pkg::PH_Q1;
		end else begin
			unique case (phase_reg)
				jie_pkg::PH_Q1: phase_reg <= jie_pkg::PH_Q2;
				jie_pkg::PH_Q2: phase_reg <= jie_pkg::PH_Q3;
				jie_pkg::PH_Q3: phase_reg <= jie_pkg::PH_Q4;
				jie_pkg::PH_Q4: phase_reg <= jie_pkg::PH_Q1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// decode and operand address
	// ----------------------------------------------------------------
	always_comb begin
		op_next = jie_pkg::OP_NONE;
		if (flush_reg || instr_reg[15:12] == jie_pkg::JIE_OPC_SECOND) begin
			op_next = jie_pkg::OP_NONE;
		end else if (instr_reg[15:8] == jie_pkg::JIE_OPC_JUMP) begin
			op_next = jie_pkg::OP_JUMP;
		end else if (instr_reg[15:10] == jie_pkg::JIE_OPC_INC) begin
			op_next = jie_pkg::OP_INC;
		end else if (instr_reg[15:10] == jie_pkg::JIE_OPC_INCSZ) begin
			op_next = jie_pkg::OP_INCSZ;
		end else if (instr_reg[15:10] == jie_pkg::JIE_OPC_INCSNZ) begin
			op_next = jie_pkg::OP_INCSNZ;
		end
	end

	always_comb begin
		if (instr_reg[8]) begin
			file_addr_next = {bank_reg, instr_reg[7:0]};
		end else if (ctrl_reg[jie_pkg::JIE_CTRL_EXT_BIT] &&
				instr_reg[7:0] <= jie_pkg::JIE_ILO_LIMIT) begin
			file_addr_next = index_reg + {4'h0, instr_reg[7:0]};
		end else if (instr_reg[7:0] < jie_pkg::JIE_ACCESS_SPLIT) begin
			file_addr_next = {4'h0, instr_reg[7:0]};
		end else begin
			file_addr_next = {jie_pkg::JIE_ACCESS_HI_BANK, instr_reg[7:0]};
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			op_reg <= jie_pkg::OP_NONE;
			dest_reg <= 1'b0;
			file_addr_reg <= 12'h000;
		end else if (run && phase_reg == jie_pkg::PH_Q1) begin
			op_reg <= op_next;
			dest_reg <= instr_reg[9];
			file_addr_reg <= file_addr_next;
		end
	end

	// ----------------------------------------------------------------
	// operand read and processing
	// ----------------------------------------------------------------
	jie_incrementer u_inc (
		.operand(operand_reg),
		.result(inc_result),
		.flags(inc_flags)
	);

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			operand_reg <= 8'h00;
			lit_lo_reg <= 8'h00;
			result_reg <= 8'h00;
			res_flags_reg <= '0;
		end else if (run) begin
			if (phase_reg == jie_pkg::PH_Q2) begin
				operand_reg <= FILE_RDATA;
				lit_lo_reg <= instr_reg[7:0];
			end
			if (phase_reg == jie_pkg::PH_Q3) begin
				result_reg <= inc_result;
				res_flags_reg <= inc_flags;
			end
		end
	end

	// write strobe stands through Q4 only; file is written at the Q4 edge
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			file_we_reg <= 1'b0;
			file_wdata_reg <= 8'h00;
		end else begin
			file_we_reg <= run && phase_reg == jie_pkg::PH_Q3 && dest_reg &&
				op_reg != jie_pkg::OP_NONE && op_reg != jie_pkg::OP_JUMP;
			if (run && phase_reg == jie_pkg::PH_Q3) begin
				file_wdata_reg <= inc_result;
			end
		end
	end

	// ----------------------------------------------------------------
	// write back, flags, counter and fetch
	// ----------------------------------------------------------------
	assign skip = (op_reg == jie_pkg::OP_INCSZ && result_reg == 8'h00) ||
		(op_reg == jie_pkg::OP_INCSNZ && result_reg != 8'h00);

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			work_reg <= jie_pkg::JIE_WORK_RST;
		end else if (run && phase_reg == jie_pkg::PH_Q4 && !dest_reg &&
				op_reg != jie_pkg::OP_NONE && op_reg != jie_pkg::OP_JUMP) begin
			work_reg <= result_reg;
		end else if (apb_wr && PADDR == jie_pkg::JIE_OFF_WORK) begin
			work_reg <= PWDATA[7:0];
		end
	end

	// skip variants and the jump leave flags alone
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			flags_reg <= '0;
		end else if (run && phase_reg == jie_pkg::PH_Q4 && op_reg == jie_pkg::OP_INC) begin
			flags_reg <= res_flags_reg;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			flush_reg <= 1'b1;
			instr_reg <= jie_pkg::JIE_INSTR_RST;
		end else if (!run) begin
			flush_reg <= 1'b1;
		end else if (phase_reg == jie_pkg::PH_Q4) begin
			instr_reg <= INSTR_WORD;
			flush_reg <= (op_reg == jie_pkg::OP_JUMP) || skip;
		end
	end

	// second jump word sits at the already advanced counter during Q4
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			counter_reg <= jie_pkg::JIE_COUNTER_RST;
		end else if (run && phase_reg == jie_pkg::PH_Q4) begin
			if (op_reg == jie_pkg::OP_JUMP) begin
				counter_reg <= {INSTR_WORD[11:0], lit_lo_reg, 1'b0};
			end else begin
				counter_reg <= counter_reg + jie_pkg::JIE_COUNTER_STEP;
			end
		end else if (!run && apb_wr && PADDR == jie_pkg::JIE_OFF_COUNTER) begin
			counter_reg <= {PWDATA[20:1], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign PROG_ADDR = counter_reg;
	assign FILE_ADDR = file_addr_reg;
	assign FILE_WDATA = file_wdata_reg;
	assign FILE_WE = file_we_reg;
endmodule
`default_nettype wire

// File: jie_exec_assertions.sv
// port-level checker for the jump and increment execute block
`timescale 1ns/10ps
`default_nettype none
module jie_exec_assertions (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [15:0] INSTR_WORD,
	input wire logic [20:0] PROG_ADDR,
	input wire logic [11:0] FILE_ADDR,
	input wire logic [7:0] FILE_RDATA,
	input wire logic [7:0] FILE_WDATA,
	input wire logic FILE_WE
);
	// ------------------------------
	// checks
	// ------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// second word seen as the counter leaves it, first word four clocks earlier
	sequence jump_seen;
		$changed(PROG_ADDR) && ($past(INSTR_WORD) & 16'hf000) == 16'hf000
			&& ($past(INSTR_WORD, 5) & 16'hff00) == 16'hef00;
	endsequence
	chk_pready_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
		else $error("ready not after one wait state");
	chk_slverr_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	chk_counter_even: assert property (PROG_ADDR[0] == 1'b0)
		else $error("program address odd");
	chk_jump_target: assert property (jump_seen |-> PROG_ADDR ==
		(((21'($past(INSTR_WORD)) & 21'hfff) << 9) | ((21'($past(INSTR_WORD, 5)) & 21'hff) << 1)))
		else $error("jump target wrong");
	chk_jump_noop: assert property (jump_seen |-> !FILE_WE [*4])
		else $error("slot after jump not idle");
	chk_we_pulse: assert property (FILE_WE |=> !FILE_WE)
		else $error("write strobe too long");
	chk_wdata_inc: assert property (FILE_WE |-> FILE_WDATA == 8'($past(FILE_RDATA) + 8'h01))
		else $error("write data not operand plus one");
	chk_we_addr: assert property (FILE_WE |-> FILE_ADDR == $past(FILE_ADDR, 2))
		else $error("write not to source register");
	chk_addr_hold: assert property ($changed(FILE_ADDR) |=> $stable(FILE_ADDR) [*3])
		else $error("file address not held");
endmodule
`default_nettype wire

// File: jie_incrementer.sv
// eight-bit incrementer with arithmetic flags
`timescale 1ns/10ps
`default_nettype none
module jie_incrementer (
	input wire logic [7:0] operand,
	output logic [7:0] result,
	output var jie_pkg::jie_flags_t flags
);
	logic [8:0] sum;

	always_comb begin
		sum = {1'b0, operand} + 9'h001;
		result = sum[7:0];
		flags.c = sum[8];
		flags.digit_carry = (operand[3:0] == 4'hf);
		flags.z = (sum[7:0] == 8'h00);
		flags.n = sum[7];
		flags.overflow = (operand == 8'h7f);
	end
endmodule
`default_nettype wire

// File: jie_mem_model.sv
// program memory and data file facing the execute block
`timescale 1ns/10ps
`default_nettype none
module jie_mem_model (
	input wire logic clk,
	input wire logic [20:0] prog_addr,
	output logic [15:0] instr_word,
	input wire logic [11:0] file_addr,
	output logic [7:0] file_rdata,
	input wire logic [7:0] file_wdata,
	input wire logic file_we
);
	// ------------------------------
	// arrays
	// ------------------------------
	// small program array: high targets alias, so programs stay short
	logic [15:0] rom [0:63];
	logic [7:0] ram [0:4095];
	assign instr_word = rom[prog_addr[6:1]];
	assign file_rdata = ram[file_addr];
	always @(posedge clk) begin
		if (file_we)
			ram[file_addr] <= file_wdata;
	end
endmodule
`default_nettype wire

// File: jie_pkg.sv
// constants, types and register map of the jump and increment execute block
//
// Notes on behaviour
// - jump loads its 20-bit literal into program_counter bits 20 down to 1.
// - jump is two words: EF plus k[7:0], then F plus k[19:8].
// - jump takes two cycles: read literals, write counter in Q4, then no operation.
// - jump reaches the whole 2-Mbyte range and leaves every flag unchanged.
// - increment_file 001010da adds one, updates carry, digit_carry_flag, negative, overflow_flag, zero.
// - direction clear writes the accumulator; set writes back the file register.
// - bank bit clear uses access bank; set uses bank_select_register with the file address.
// - bank bit clear, extended set on, address up to 5Fh uses indexed literal offset.
// - incrementing FFh wraps to 00h and sets zero, carry and digit_carry_flag.
`default_nettype none
package jie_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] JIE_OFF_CTRL = 8'h00;
	localparam logic [7:0] JIE_OFF_BANK = 8'h04;
	localparam logic [7:0] JIE_OFF_WORK = 8'h08;
	localparam logic [7:0] JIE_OFF_FLAGS = 8'h0c;
	localparam logic [7:0] JIE_OFF_COUNTER = 8'h10;
	localparam logic [7:0] JIE_OFF_INDEX = 8'h14;

	localparam int JIE_CTRL_RUN_BIT = 0;
	localparam int JIE_CTRL_EXT_BIT = 1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] JIE_CTRL_RST = 2'h0;
	localparam logic [3:0] JIE_BANK_RST = 4'h0;
	localparam logic [7:0] JIE_WORK_RST = 8'h00;
	localparam logic [11:0] JIE_INDEX_RST = 12'h000;
	localparam logic [20:0] JIE_COUNTER_RST = 21'h000000;
	localparam logic [15:0] JIE_INSTR_RST = 16'h0000;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] JIE_OPC_JUMP = 8'hef;
	localparam logic [3:0] JIE_OPC_SECOND = 4'hf;
	localparam logic [5:0] JIE_OPC_INC = 6'h0a;
	localparam logic [5:0] JIE_OPC_INCSZ = 6'h0f;
	localparam logic [5:0] JIE_OPC_INCSNZ = 6'h12;

	// ----------------------------------------------------------------
	// addressing
	// ----------------------------------------------------------------
	localparam logic [7:0] JIE_ILO_LIMIT = 8'h5f;
	localparam logic [7:0] JIE_ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] JIE_ACCESS_HI_BANK = 4'hf;
	localparam logic [20:0] JIE_COUNTER_STEP = 21'h000002;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} jie_phase_t;
	typedef enum logic [2:0] {OP_NONE, OP_JUMP, OP_INC, OP_INCSZ, OP_INCSNZ} jie_op_t;

	// bit 0 carry up to bit 4 negative
	typedef struct packed {
		logic n;
		logic overflow;
		logic z;
		logic digit_carry;
		logic c;
	} jie_flags_t;

endpackage
`default_nettype wire

// File: tb.sv
// self-checking bench for the jump and increment execute block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic MCLK = 1'b0;
	logic RESETN = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic [15:0] INSTR_WORD;
	logic [20:0] PROG_ADDR;
	logic [11:0] FILE_ADDR;
	logic [7:0] FILE_RDATA;
	logic [7:0] FILE_WDATA;
	logic FILE_WE;
	int mismatches = 0;
	int compares = 0;
	int seed = 64;
	logic [33:0] exp_q [$];
	logic [33:0] ex;
	logic [7:0] rv [0:3];
	logic [11:0] idx;
	logic [3:0] bnk;
	always #2.5 MCLK = ~MCLK;
	jie_exec u_jie_exec (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .INSTR_WORD(INSTR_WORD), .PROG_ADDR(PROG_ADDR),
		.FILE_ADDR(FILE_ADDR), .FILE_RDATA(FILE_RDATA), .FILE_WDATA(FILE_WDATA),
		.FILE_WE(FILE_WE));
	jie_mem_model u_jie_mem_model (.clk(MCLK), .prog_addr(PROG_ADDR), .instr_word(INSTR_WORD),
		.file_addr(FILE_ADDR), .file_rdata(FILE_RDATA), .file_wdata(FILE_WDATA),
		.file_we(FILE_WE));
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ram_is(input logic [11:0] a, input logic [7:0] e);
		cmp("ram", {24'h0, e}, {24'h0, u_jie_mem_model.ram[a]});
	endtask
	task automatic put(input int p, input logic [15:0] w, input logic [11:0] a,
		input logic [7:0] v);
		u_jie_mem_model.rom[p] = w;
		u_jie_mem_model.ram[a] = v;
	endtask
	// expectation is {read, error, data}
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		exp_q.push_back({~w, e});
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge MCLK) begin
		if (PREADY === 1'b1 && exp_q.size() > 0) begin
			ex = exp_q.pop_front();
			cmp("PSLVERR", {31'h0, ex[32]}, {31'h0, PSLVERR});
			if (ex[33])
				cmp("PRDATA", ex[31:0], PRDATA);
		end
	end
	initial begin
		repeat (3000) @(posedge MCLK);
		mismatches++;
		$display("ERROR watchdog expected end seen hang");
		wrap_up();
	end
	// ------------------------------
	// tests
	// ------------------------------
	initial begin
		for (int i = 0; i < 4096; i++)
			u_jie_mem_model.ram[i] = 8'($random(seed));
		for (int i = 0; i < 64; i++)
			u_jie_mem_model.rom[i] = 16'hf000;
		for (int i = 0; i < 4; i++)
			rv[i] = 8'($random(seed)) & 8'h7f;
		// odd banks 1, 3, 5 or 7 keep every operand clear of the access bank and index area
		bnk = 4'($random(seed)) & 4'h7 | 4'h1;
		idx = 12'($random(seed)) & 12'h0ff | 12'h800;
		put(0, {6'h0a, 2'h3, 8'h31}, {bnk, 8'h31}, 8'hff);
		put(1, {6'h0a, 2'h0, 8'h70}, 12'hf70, rv[0]);
		put(2, 16'hef10, 12'h0, 8'h0);
		put(3, 16'hf800, 12'h0, 8'h0);
		put(16, {6'h0a, 2'h2, 8'h05}, idx + 12'h005, 8'hff);
		put(17, {6'h0f, 2'h3, 8'h32}, {bnk, 8'h32}, 8'hff);
		put(18, {6'h0a, 2'h3, 8'h33}, {bnk, 8'h33}, rv[1]);
		put(19, {6'h12, 2'h3, 8'h34}, {bnk, 8'h34}, rv[2]);
		put(20, {6'h0a, 2'h3, 8'h35}, {bnk, 8'h35}, rv[3]);
		put(44, {6'h0a, 2'h2, 8'h05}, 12'h005, 8'h7f);
		repeat (12) @(posedge MCLK);
		RESETN <= 1'b1;
		for (int a = 0; a < 28; a += 4)
			apb(1'b0, 8'(a), 32'h0, {a == 24, 32'h0});
		$display("test reset values done");
		apb(1'b1, 8'h04, {28'($random(seed)), bnk}, 33'h0);
		apb(1'b0, 8'h04, 32'h0, 33'(bnk));
		apb(1'b1, 8'h14, {20'($random(seed)), idx}, 33'h0);
		apb(1'b0, 8'h14, 32'h0, 33'(idx));
		apb(1'b1, 8'h0c, 32'h1f, 33'h0);
		apb(1'b0, 8'h0c, 32'h0, 33'h0);
		apb(1'b1, 8'h10, 32'h001ffff3, 33'h0);
		apb(1'b0, 8'h10, 32'h0, 33'h1ffff2);
		apb(1'b1, 8'h10, 32'h0, 33'h0);
		apb(1'b1, 8'h18, 32'hffffffff, 33'h100000000);
		$display("test register access done");
		apb(1'b1, 8'h00, 32'h3, 33'h0);
		repeat (120) @(posedge MCLK);
		apb(1'b1, 8'h00, 32'h2, 33'h0);
		ram_is({bnk, 8'h31}, 8'h00);
		apb(1'b0, 8'h08, 32'h0, 33'(rv[0] + 8'h01));
		ram_is(12'hf70, rv[0]);
		ram_is(idx + 12'h005, 8'h00);
		ram_is({bnk, 8'h32}, 8'h00);
		ram_is({bnk, 8'h33}, rv[1]);
		ram_is({bnk, 8'h34}, rv[2] + 8'h01);
		ram_is({bnk, 8'h35}, rv[3]);
		apb(1'b0, 8'h0c, 32'h0, 33'h07);
		$display("test program run done");
		// extended set off: low access bank, overflow and negative flags
		apb(1'b1, 8'h10, 32'h58, 33'h0);
		apb(1'b1, 8'h00, 32'h1, 33'h0);
		repeat (20) @(posedge MCLK);
		apb(1'b1, 8'h00, 32'h0, 33'h0);
		ram_is(12'h005, 8'h80);
		apb(1'b0, 8'h0c, 32'h0, 33'h1a);
		repeat (2) @(posedge MCLK);
		$display("test access bank run done");
		wrap_up();
	end
endmodule
bind jie_exec jie_exec_assertions u_jie_exec_assertions (.MCLK(MCLK), .RESETN(RESETN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.INSTR_WORD(INSTR_WORD), .PROG_ADDR(PROG_ADDR), .FILE_ADDR(FILE_ADDR),
	.FILE_RDATA(FILE_RDATA), .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE));
`default_nettype wire
